// [vbc_board.sv]
// board end: one slave window, one master port, one interrupter
module vbc_board
    import vbc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    vbc_if.board bus,
    input wire vbc_space_t slv_space,
    input wire logic [63:0] slv_base,
    input wire logic [63:0] slv_mask,
    input wire logic [63:0] slv_rdata,
    output logic slv_wr,
    output logic [63:0] slv_waddr,
    output logic [63:0] slv_wdata,
    input wire logic mst_req,
    input wire logic [5:0] mst_am,
    input wire logic [63:0] mst_addr,
    input wire vbc_size_t mst_size,
    input wire logic mst_write,
    input wire logic [63:0] mst_wdata,
    output logic mst_done,
    output logic [63:0] mst_rdata,
    input wire logic [2:0] irq_lvl,
    input wire logic irq_req,
    input wire logic [7:0] irq_vector,
    output logic irq_acked
);
    typedef enum logic [1:0] {VBB_IDLE = 2'h0, VBB_REQ = 2'h1, VBB_RUN = 2'h3,
        VBB_END = 2'h2} vbb_state_t;
    typedef struct packed {
        vbb_state_t st;
        logic dtack;
        logic [63:0] rdata;
        logic slv_wr;
        logic [63:0] slv_waddr;
        logic [63:0] slv_wdata;
        logic irq_pend;
        logic vec_done;
        logic mst_done;
        logic [63:0] mst_rdata;
        logic irq_acked;
    } vbb_reg_t;
    vbb_reg_t r_q;
    vbb_reg_t r_d;
    logic hit;

    always_comb
    begin
        r_d = r_q;
        r_d.slv_wr = 1'b0;
        r_d.mst_done = 1'b0;
        r_d.irq_acked = 1'b0;
        // RULE2 RULE8
        // a32 and a64 codes share am[5:4]; only am[3] tells them apart
        hit = bus.as_act && !bus.iack && (bus.am[5:3] == 3'b001 ? slv_space == VBC_SP_A32 :
            bus.am[5:3] == 3'b000 ? slv_space == VBC_SP_A64 :
            bus.am[5:4] == 2'b10 ? slv_space == VBC_SP_A16 :
            bus.am[5:4] == 2'b11 ? slv_space == VBC_SP_A24 : 1'b0)
            && ((bus.addr & slv_mask) == slv_base);
        if (hit && bus.ds_act && !r_q.dtack)
        begin
            r_d.dtack = 1'b1;
            if (bus.write)
            begin
                r_d.slv_wr = 1'b1; // RULE9
                r_d.slv_waddr = bus.addr;
                r_d.slv_wdata = bus.wdata;
            end
            else
                r_d.rdata = slv_rdata;
        end
        else if (!bus.ds_act)
            r_d.dtack = 1'b0;
        if (irq_req && !r_q.irq_pend)
            r_d.irq_pend = 1'b1; // RULE12
        if (bus.iack && bus.iack_lvl == irq_lvl && r_q.irq_pend && !r_q.vec_done)
        begin
            r_d.vec_done = 1'b1; // RULE13
            r_d.irq_pend = 1'b0;
            r_d.irq_acked = 1'b1;
        end
        else if (!bus.iack)
            r_d.vec_done = 1'b0;
        case (r_q.st)
            VBB_IDLE:
                if (mst_req)
                    r_d.st = VBB_REQ;
            VBB_REQ:
                if (bus.bg[1])
                    r_d.st = VBB_RUN; // RULE7
            VBB_RUN:
                if (bus.s_dtack)
                begin
                    r_d.mst_rdata = bus.s_rdata;
                    r_d.mst_done = 1'b1;
                    r_d.st = VBB_END;
                end
            VBB_END:
                if (!bus.s_dtack)
                    r_d.st = VBB_IDLE;
            default:
                r_d.st = VBB_IDLE;
        endcase
        if (sys_rst)
        begin
            r_d = '0;
            r_d.st = VBB_IDLE;
        end
    end

    always_ff @(posedge clk)
        r_q <= r_d;

    assign bus.br = {r_q.st != VBB_IDLE, 1'b0};
    assign bus.rdata = r_q.rdata;
    assign bus.dtack = r_q.dtack;
    assign bus.irq = r_q.irq_pend ? 7'(7'h01 << (irq_lvl - 3'h1)) : 7'h00;
    assign bus.vector = irq_vector;
    assign bus.iack_done = r_q.vec_done;
    // RULE6
    assign bus.m_as = r_q.st == VBB_RUN;
    assign bus.m_ds = r_q.st == VBB_RUN;
    assign bus.m_am = mst_am;
    assign bus.m_addr = mst_addr;
    assign bus.m_size = mst_size;
    assign bus.m_write = mst_write;
    assign bus.m_wdata = mst_wdata;
    assign slv_wr = r_q.slv_wr;
    assign slv_waddr = r_q.slv_waddr;
    assign slv_wdata = r_q.slv_wdata;
    assign mst_done = r_q.mst_done;
    assign mst_rdata = r_q.mst_rdata;
    assign irq_acked = r_q.irq_acked;
endmodule

// [vbc_checker.sv]
// concurrent checks on the bus joining controller and board
`include "vbc_map.svh"
module vbc_checker
    import vbc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [1:0] br,
    input wire logic [1:0] bg,
    input wire logic as_act,
    input wire logic [5:0] am,
    input wire logic [63:0] addr,
    input wire logic write,
    input wire logic ds_act,
    input wire logic dtack,
    input wire logic [6:0] irq,
    input wire logic iack,
    input wire logic [2:0] iack_lvl,
    input wire logic iack_done,
    input wire logic m_as,
    input wire logic [5:0] m_am,
    input wire logic [63:0] m_addr,
    input wire logic s_dtack
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ========
    // steps
    sequence ack_start;
        $rose(iack) && iack_lvl != 3'h0;
    endsequence
    // any a32 code, data, block or program, both privilege kinds
    sequence slv_hit;
        m_as && m_am[5:3] == 3'h1 && ((m_addr & `VBC_SLV_MASK) == `VBC_SLV_BASE);
    endsequence
    // ========
    // properties
    chk_grant_on_req: assert property (bg[1] |-> br[1])
        else $error("grant seen without request");
    chk_owner_drives: assert property (as_act |-> !bg[1])
        else $error("controller cycle while board owns bus");
    chk_data_codes: assert property (as_act && !iack |-> am[1:0] != 2'h2)
        else $error("program area modifier driven");
    chk_cycle_hold: assert property (ds_act && $past(ds_act) |-> $stable(addr) && $stable(write))
        else $error("address or direction moved in a cycle");
    chk_strobe_inside: assert property (ds_act |-> as_act)
        else $error("data strobe without address strobe");
    chk_ds_release: assert property ($rose(dtack) |-> ##[1:4] !ds_act)
        else $error("data strobe held after dtack");
    chk_iack_level: assert property (ack_start |-> irq[iack_lvl - 3'h1])
        else $error("acknowledge on a quiet level");
    chk_vector_back: assert property (ack_start |-> ##[1:16] iack_done)
        else $error("no vector returned");
    chk_slave_hit: assert property ($rose(s_dtack) |-> slv_hit)
        else $error("controller answered a foreign address");
endmodule

// [vbc_ctrl.sv]
// controller end: host window master, host memory slave, irq handler
// =====================================================================
// Notes on behaviour
// RULE1 - addresses carry 16, 24, 32 or 64 bits
// RULE2 - each address width decoded as separate space
// RULE3 - modifier bits give space, block, data/super
// RULE4 - only supervisor or user data codes used
// RULE5 - one unit of 8..64 bits per cycle
// RULE6 - master owns bus, then drives cycle fields
// RULE7 - masters share bus through arbitration
// RULE8 - slave answers only its own addresses
// RULE9 - read slave to master, write master to slave
// RULE10 - modify write follows read, same address
// RULE11 - block moves successive addresses back to back
// RULE12 - interrupts on seven levels
// RULE13 - acknowledge cycle returns requester vector
// RULE14 - enabled levels acknowledged and forwarded to cpu
// RULE15 - disabled levels left for other handlers
// RULE16 - host window access becomes bus cycle
// RULE17 - external master hit becomes host memory access
// RULE18 - per-level enable bits from host
// RULE19 - latch acknowledged vector with its level
`include "vbc_map.svh"
module vbc_ctrl
    import vbc_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    vbc_if.ctrl bus,
    input wire logic host_req,
    input wire vbc_op_t host_op,
    input wire vbc_space_t host_space,
    input wire logic host_super,
    input wire vbc_size_t host_size,
    input wire logic [63:0] host_addr,
    input wire logic [63:0] host_wdata,
    input wire logic [63:0] host_mask,
    input wire logic [3:0] host_len,
    output logic host_ack,
    output logic host_busy,
    output logic [63:0] host_rdata,
    input wire logic [6:0] irq_enable,
    output logic cpu_irq,
    input wire logic cpu_irq_clr,
    output logic [7:0] irq_vector,
    output logic [2:0] irq_level,
    output logic mem_req,
    output logic mem_write,
    output logic [63:0] mem_addr,
    output logic [63:0] mem_wdata,
    input wire logic [63:0] mem_rdata,
    input wire logic mem_ack
);
    // =================================================================
    // state
    typedef enum logic [2:0] {VBC_IDLE = 3'h0, VBC_ARB = 3'h1, VBC_ADDR = 3'h3,
        VBC_DATA = 3'h2, VBC_REL = 3'h6, VBC_IACK = 3'h7, VBC_SLV = 3'h5,
        VBC_SREL = 3'h4} vbc_state_t;
    typedef struct packed {
        vbc_state_t st;
        logic own;
        logic as_act;
        logic ds_act;
        logic [5:0] am;
        logic [63:0] addr;
        vbc_size_t size;
        logic write;
        logic [63:0] wdata;
        vbc_op_t op;
        logic rmw_wr;
        logic [3:0] left;
        logic [63:0] hmask;
        logic ack;
        logic [63:0] rdata;
        logic iack;
        logic [2:0] lvl;
        logic cpu_irq;
        logic [7:0] vec;
        logic [2:0] vlvl;
        logic mreq;
        logic mwr;
        logic [63:0] maddr;
        logic [63:0] mwdata;
        logic s_dtack;
        logic [63:0] s_rdata;
        logic [1:0] gnt;
    } vbc_reg_t;
    vbc_reg_t r_q;
    vbc_reg_t r_d;
    logic [6:0] irq_take;
    logic [2:0] irq_pick;
    logic slv_hit;
    logic [63:0] step;

    // =================================================================
    // modifier encode
    function automatic logic [5:0] am_code(vbc_space_t sp, logic sup, logic blk);
        logic [5:0] c;
        c = 6'h00;
        case (sp) // RULE1 RULE3 RULE4
            VBC_SP_A16: c = sup ? `VBC_AM_A16_SD : `VBC_AM_A16_UD;
            VBC_SP_A24: c = sup ? (blk ? `VBC_AM_A24_SB : `VBC_AM_A24_SD)
                : (blk ? `VBC_AM_A24_UB : `VBC_AM_A24_UD);
            VBC_SP_A32: c = sup ? (blk ? `VBC_AM_A32_SB : `VBC_AM_A32_SD)
                : (blk ? `VBC_AM_A32_UB : `VBC_AM_A32_UD);
            VBC_SP_A64: c = sup ? (blk ? `VBC_AM_A64_SB : `VBC_AM_A64_SD)
                : (blk ? `VBC_AM_A64_UB : `VBC_AM_A64_UD);
            default: c = `VBC_AM_A32_SD;
        endcase
        return c;
    endfunction

    function automatic logic am_is_data(logic [5:0] a);
        return a == `VBC_AM_A16_SD || a == `VBC_AM_A16_UD || a == `VBC_AM_A24_SD
            || a == `VBC_AM_A24_UD || a == `VBC_AM_A24_SB || a == `VBC_AM_A24_UB
            || a == `VBC_AM_A32_SD || a == `VBC_AM_A32_UD || a == `VBC_AM_A32_SB
            || a == `VBC_AM_A32_UB || a == `VBC_AM_A64_SD || a == `VBC_AM_A64_SB
            || a == `VBC_AM_A64_UD || a == `VBC_AM_A64_UB;
    endfunction

    // =================================================================
    // interrupt level pick, highest first
    assign irq_take = bus.irq & irq_enable; // RULE15 RULE18
    always_comb
    begin
        irq_pick = 3'h0;
        for (int i = 0; i < `VBC_IRQ_LEVELS; i++)
            if (irq_take[i])
                irq_pick = 3'(i + 1);
    end

    // A32 window at the slave base; code-area cycles never match
    assign slv_hit = bus.m_as && am_is_data(bus.m_am) // RULE4 RULE17
        && bus.m_am[5:4] == 2'b00 && bus.m_am[3] == 1'b1
        && ((bus.m_addr & `VBC_SLV_MASK) == `VBC_SLV_BASE); // RULE2 RULE8
    assign step = 64'h1 << r_q.size; // RULE5 RULE11

    // =================================================================
    // next state
    always_comb
    begin
        r_d = r_q;
        r_d.ack = 1'b0;
        r_d.gnt = 2'b00;
        if (cpu_irq_clr)
            r_d.cpu_irq = 1'b0;
        case (r_q.st)
            VBC_IDLE:
                if (bus.br[1] && !host_req && irq_pick == 3'h0)
                begin
                    r_d.gnt = 2'b10; // RULE7
                    r_d.st = VBC_SLV;
                end
                else if (irq_pick != 3'h0 && !r_q.cpu_irq)
                begin
                    r_d.lvl = irq_pick; // RULE14
                    r_d.st = VBC_IACK;
                end
                else if (host_req)
                begin
                    // RULE16 window translation by mask
                    r_d.addr = host_addr & `VBC_WIN_MASK & host_mask;
                    r_d.op = host_op;
                    r_d.hmask = host_mask;
                    r_d.size = host_size;
                    r_d.write = host_op == VBC_OP_WR;
                    r_d.wdata = host_wdata;
                    r_d.am = am_code(host_space, host_super, host_op == VBC_OP_BLK);
                    r_d.left = host_len;
                    r_d.rmw_wr = 1'b0;
                    r_d.st = VBC_ARB;
                end
            VBC_ARB:
            begin
                r_d.own = 1'b1; // RULE6 RULE7
                r_d.st = VBC_ADDR;
            end
            VBC_ADDR:
            begin
                r_d.as_act = 1'b1; // RULE6
                r_d.ds_act = 1'b1;
                r_d.st = VBC_DATA;
            end
            VBC_DATA:
                if (bus.dtack)
                begin
                    r_d.ds_act = 1'b0;
                    if (!r_q.write)
                        r_d.rdata = bus.rdata; // RULE9
                    r_d.st = VBC_REL;
                end
            VBC_REL:
                if (!bus.dtack)
                begin
                    if (r_q.op == VBC_OP_RMW && !r_q.rmw_wr)
                    begin
                        r_d.rmw_wr = 1'b1; // RULE10
                        r_d.write = 1'b1;
                        r_d.wdata = host_wdata;
                        r_d.ds_act = 1'b1;
                        r_d.st = VBC_DATA;
                    end
                    else if (r_q.op == VBC_OP_BLK && r_q.left != 4'h0)
                    begin
                        r_d.left = r_q.left - 4'h1; // RULE11
                        r_d.addr = r_q.addr + step;
                        r_d.ds_act = 1'b1;
                        r_d.ack = 1'b1;
                        r_d.st = VBC_DATA;
                    end
                    else
                    begin
                        r_d.as_act = 1'b0;
                        r_d.own = 1'b0;
                        r_d.ack = 1'b1;
                        r_d.st = VBC_IDLE;
                    end
                end
            VBC_IACK:
            begin
                r_d.iack = 1'b1; // RULE13
                if (r_q.iack && bus.iack_done)
                begin
                    r_d.vec = bus.vector; // RULE19
                    r_d.vlvl = r_q.lvl;
                    r_d.cpu_irq = 1'b1; // RULE14
                    r_d.iack = 1'b0;
                    r_d.st = VBC_IDLE;
                end
            end
            VBC_SLV:
            begin
                r_d.gnt = 2'b10;
                if (!bus.m_as)
                    r_d.st = VBC_IDLE;
                else if (slv_hit && bus.m_ds && !r_q.mreq && !r_q.s_dtack)
                begin
                    r_d.mreq = 1'b1; // RULE17
                    r_d.mwr = bus.m_write;
                    r_d.maddr = bus.m_addr;
                    r_d.mwdata = bus.m_wdata;
                end
                else if (r_q.mreq && mem_ack)
                begin
                    r_d.mreq = 1'b0;
                    r_d.s_rdata = mem_rdata;
                    r_d.s_dtack = 1'b1;
                    r_d.st = VBC_SREL;
                end
            end
            VBC_SREL:
            begin
                r_d.gnt = 2'b10;
                if (!bus.m_ds)
                begin
                    r_d.s_dtack = 1'b0;
                    r_d.st = VBC_SLV;
                end
            end
            default:
                r_d.st = VBC_IDLE;
        endcase
        if (sys_rst)
        begin
            r_d = '0;
            r_d.st = VBC_IDLE;
        end
    end

    always_ff @(posedge clk)
        r_q <= r_d;

    // =================================================================
    // outputs
    assign bus.bg = r_d.gnt;
    assign bus.as_act = r_q.as_act;
    assign bus.ds_act = r_q.ds_act;
    assign bus.am = r_q.am;
    assign bus.addr = r_q.addr;
    assign bus.size = r_q.size;
    assign bus.write = r_q.write;
    assign bus.wdata = r_q.wdata;
    assign bus.iack = r_q.iack;
    assign bus.iack_lvl = r_q.lvl;
    assign bus.s_rdata = r_q.s_rdata;
    assign bus.s_dtack = r_q.s_dtack;
    assign host_ack = r_q.ack;
    assign host_busy = r_q.st != VBC_IDLE;
    assign host_rdata = r_q.rdata;
    assign cpu_irq = r_q.cpu_irq;
    assign irq_vector = r_q.vec;
    assign irq_level = r_q.vlvl;
    assign mem_req = r_q.mreq;
    assign mem_write = r_q.mwr;
    assign mem_addr = r_q.maddr;
    assign mem_wdata = r_q.mwdata;
endmodule

// [vbc_if.sv]
// abstract bus between the controller and a board
interface vbc_if;
    import vbc_pkg::*;
    logic [1:0] br;
    logic [1:0] bg;
    logic as_act;
    logic [5:0] am;
    logic [63:0] addr;
    vbc_size_t size;
    logic write;
    logic [63:0] wdata;
    logic ds_act;
    logic [63:0] rdata;
    logic dtack;
    logic [6:0] irq;
    logic iack;
    logic [2:0] iack_lvl;
    logic [7:0] vector;
    logic iack_done;
    logic m_as;
    logic [5:0] m_am;
    logic [63:0] m_addr;
    vbc_size_t m_size;
    logic m_write;
    logic [63:0] m_wdata;
    logic m_ds;
    logic [63:0] s_rdata;
    logic s_dtack;
    modport ctrl (output bg, as_act, am, addr, size, write, wdata, ds_act,
        iack, iack_lvl, s_rdata, s_dtack,
        input br, rdata, dtack, irq, vector, iack_done,
        m_as, m_am, m_addr, m_size, m_write, m_wdata, m_ds);
    modport board (input bg, as_act, am, addr, size, write, wdata, ds_act,
        iack, iack_lvl, s_rdata, s_dtack,
        output br, rdata, dtack, irq, vector, iack_done,
        m_as, m_am, m_addr, m_size, m_write, m_wdata, m_ds);
endinterface

// [vbc_map.svh]
// constants for the bus controller and its board-side partner
`ifndef VBC_MAP_SVH
`define VBC_MAP_SVH
`define VBC_AM_A16_SD 6'h2d
`define VBC_AM_A16_UD 6'h29
`define VBC_AM_A24_SD 6'h3d
`define VBC_AM_A24_UD 6'h39
`define VBC_AM_A24_SB 6'h3f
`define VBC_AM_A24_UB 6'h3b
`define VBC_AM_A32_SD 6'h0d
`define VBC_AM_A32_UD 6'h09
`define VBC_AM_A32_SB 6'h0f
`define VBC_AM_A32_UB 6'h0b
`define VBC_AM_A64_SD 6'h01
`define VBC_AM_A64_SB 6'h03
`define VBC_AM_A64_UD 6'h05
`define VBC_AM_A64_UB 6'h07
`define VBC_AM_BLOCK_BIT 1
`define VBC_AM_SUPER_BIT 2
`define VBC_IRQ_LEVELS 7
`define VBC_WIN_BASE 64'h0000_0000_0000_0000
`define VBC_WIN_MASK 64'hffff_ffff_ffff_ffff
`define VBC_SLV_BASE 64'h0000_0000_0010_0000
`define VBC_SLV_MASK 64'hffff_ffff_fff0_0000
`define VBC_RST_EN 7'h00
`endif

// [vbc_pkg.sv]
// types shared by both ends of the bus
package vbc_pkg;
    typedef enum logic [1:0] {VBC_SP_A16 = 2'h0, VBC_SP_A24 = 2'h1,
        VBC_SP_A32 = 2'h2, VBC_SP_A64 = 2'h3} vbc_space_t;
    typedef enum logic [1:0] {VBC_SZ_D8 = 2'h0, VBC_SZ_D16 = 2'h1,
        VBC_SZ_D32 = 2'h2, VBC_SZ_D64 = 2'h3} vbc_size_t;
    typedef enum logic [1:0] {VBC_OP_RD = 2'h0, VBC_OP_WR = 2'h1,
        VBC_OP_RMW = 2'h2, VBC_OP_BLK = 2'h3} vbc_op_t;
endpackage

// [vbc_tb.sv]
// testbench: controller and board joined back to back
`include "vbc_map.svh"
module testbench
    import vbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {vbc_space_t sp; vbc_size_t sz; logic su; logic [5:0] am;
        logic [63:0] a; logic [63:0] d;} vbc_row_t;
    vbc_row_t rows [4] = '{
        '{VBC_SP_A16, VBC_SZ_D8, 1'b1, `VBC_AM_A16_SD, 64'h40, 64'h5a},
        '{VBC_SP_A24, VBC_SZ_D16, 1'b0, `VBC_AM_A24_UD, 64'h12_3400, 64'h1234},
        '{VBC_SP_A32, VBC_SZ_D32, 1'b1, `VBC_AM_A32_SD, 64'h8000_1000, 64'hdead_beef},
        '{VBC_SP_A64, VBC_SZ_D64, 1'b0, `VBC_AM_A64_UD, 64'h1_2000_0000, 64'h0123_4567}};
    logic clk, sys_rst = 1'b1, host_req = 1'b0, host_super = 1'b0, cpu_irq_clr = 1'b0;
    logic mem_ack = 1'b0, mst_req = 1'b0, mst_write = 1'b0, irq_req = 1'b0;
    logic host_ack, host_busy, cpu_irq, mem_req, mem_write, slv_wr, mst_done, irq_acked;
    vbc_op_t host_op = VBC_OP_RD;
    vbc_space_t host_space = VBC_SP_A16, slv_space = VBC_SP_A16;
    vbc_size_t host_size = VBC_SZ_D8, mst_size = VBC_SZ_D32;
    logic [63:0] host_addr = 64'h0, host_wdata = 64'h0, mem_rdata = 64'h0;
    logic [63:0] slv_rdata = 64'h0, mst_addr = 64'h0, mst_wdata = 64'h0;
    logic [63:0] host_rdata, mem_addr, mem_wdata, slv_waddr, slv_wdata, mst_rdata;
    logic [63:0] last_wa, last_wd, mem_wd, last_ba;
    logic [3:0] host_len = 4'h0;
    logic [6:0] irq_enable = 7'h00;
    logic [7:0] irq_vector, brd_vec = 8'h00;
    logic [2:0] irq_level, irq_lvl = 3'h1;
    logic [5:0] mst_am = 6'h00, am_seen;
    logic mem_wr, mreq_seen, iack_seen, dtack_q;
    int num_errors = 0, n_compared = 0, n_wr = 0, n0, n_beat = 0, n_ack = 0;
    vbc_if vbc_if_inst ();
    vbc_ctrl vbc_ctrl_inst (.clk, .sys_rst, .bus(vbc_if_inst.ctrl), .host_req, .host_op,
        .host_space, .host_super, .host_size, .host_addr, .host_wdata,
        .host_mask(64'hffff_ffff_ffff_ffff), .host_len, .host_ack, .host_busy, .host_rdata,
        .irq_enable, .cpu_irq, .cpu_irq_clr, .irq_vector, .irq_level, .mem_req,
        .mem_write, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
    vbc_board vbc_board_inst (.clk, .sys_rst, .bus(vbc_if_inst.board), .slv_space,
        .slv_base(64'h0), .slv_mask(64'h0), .slv_rdata, .slv_wr, .slv_waddr, .slv_wdata,
        .mst_req, .mst_am, .mst_addr, .mst_size, .mst_write, .mst_wdata, .mst_done,
        .mst_rdata, .irq_lvl, .irq_req, .irq_vector(brd_vec), .irq_acked);
    vbc_checker vbc_checker_inst (.clk, .sys_rst, .br(vbc_if_inst.br), .bg(vbc_if_inst.bg),
        .as_act(vbc_if_inst.as_act), .am(vbc_if_inst.am), .addr(vbc_if_inst.addr),
        .write(vbc_if_inst.write), .ds_act(vbc_if_inst.ds_act), .dtack(vbc_if_inst.dtack),
        .irq(vbc_if_inst.irq), .iack(vbc_if_inst.iack), .iack_lvl(vbc_if_inst.iack_lvl),
        .iack_done(vbc_if_inst.iack_done), .m_as(vbc_if_inst.m_as), .m_am(vbc_if_inst.m_am),
        .m_addr(vbc_if_inst.m_addr), .s_dtack(vbc_if_inst.s_dtack));
    // ========
    // clock, monitors, host memory
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (slv_wr === 1'b1)
        begin
            n_wr <= n_wr + 1;
            last_wa <= slv_waddr;
            last_wd <= slv_wdata;
        end
        if (vbc_if_inst.as_act === 1'b1 && vbc_if_inst.iack !== 1'b1)
            am_seen <= vbc_if_inst.am;
        if (vbc_if_inst.iack === 1'b1)
            iack_seen <= 1'b1;
        // rising dtack marks one finished beat, read or write
        dtack_q <= vbc_if_inst.dtack;
        if (vbc_if_inst.dtack === 1'b1 && dtack_q !== 1'b1)
        begin
            n_beat <= n_beat + 1;
            last_ba <= vbc_if_inst.addr;
        end
        if (irq_acked === 1'b1)
            n_ack <= n_ack + 1;
    end
    // one-cycle ack, so a held request is never served twice
    always @(negedge clk)
    begin
        mem_ack <= (mem_req === 1'b1) && !mem_ack;
        if (mem_req === 1'b1)
        begin
            mreq_seen <= 1'b1;
            mem_wd <= mem_wdata;
            mem_wr <= mem_write;
        end
    end
    // ========
    // tasks
    task automatic check(string w, logic [63:0] s, logic [63:0] e);
        n_compared++;
        if (s !== e)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic wait_hi(ref logic sig);
        int n;
        n = 0;
        // looked at off the edge, so a request can drop inside the answer cycle
        @(negedge clk);
        while (sig !== 1'b1 && n < 300)
        begin
            @(negedge clk);
            n++;
        end
        if (n == 300)
            num_errors++;
    endtask
    task automatic host_run(vbc_op_t op, vbc_space_t sp, vbc_size_t sz, logic su,
        logic [63:0] a, logic [63:0] d, logic [3:0] len);
        @(negedge clk);
        host_req = 1'b1;
        host_op = op;
        host_space = sp;
        host_size = sz;
        host_super = su;
        host_addr = a;
        host_wdata = d;
        host_len = len;
        repeat (len + 1) wait_hi(host_ack);
        host_req = 1'b0;
    endtask
    task automatic brd_run(logic [5:0] am, logic [63:0] a, logic w, logic [63:0] d);
        @(negedge clk);
        mst_req = 1'b1;
        mst_am = am;
        mst_addr = a;
        mst_write = w;
        mst_wdata = d;
        wait_hi(mst_done);
        mst_req = 1'b0;
    endtask
    task automatic complete_run();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ========
    // scenarios
    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        foreach (rows[i])
        begin
            slv_space = rows[i].sp;
            slv_rdata = rows[i].d;
            host_run(VBC_OP_WR, rows[i].sp, rows[i].sz, rows[i].su, rows[i].a, rows[i].d, 0);
            check("modifier", am_seen, rows[i].am);
            check("slave addr", last_wa, rows[i].a);
            check("slave wdata", last_wd, rows[i].d);
            check("host busy", host_busy, 64'h0);
            host_run(VBC_OP_RD, rows[i].sp, rows[i].sz, rows[i].su, rows[i].a, 0, 0);
            check("host rdata", host_rdata, rows[i].d);
        end
        slv_space = VBC_SP_A32;
        slv_rdata = 64'h77;
        n0 = n_wr;
        host_run(VBC_OP_RMW, VBC_SP_A32, VBC_SZ_D32, 1'b0, 64'h8000_2000, 64'h78, 0);
        check("rmw read", host_rdata, 64'h77);
        check("rmw addr", last_wa, 64'h8000_2000);
        check("rmw wdata", last_wd, 64'h78);
        check("rmw writes", 64'(n_wr - n0), 64'h1);
        // block cycles run as reads, so beats are counted on dtack
        n0 = n_beat;
        host_run(VBC_OP_BLK, VBC_SP_A32, VBC_SZ_D32, 1'b0, 64'h8000_3000, 64'h99, 4'h2);
        check("block beats", 64'(n_beat - n0), 64'h3);
        check("block last", last_ba, 64'h8000_3008);
        check("block code", am_seen, `VBC_AM_A32_UB);
        brd_run(`VBC_AM_A32_UD, `VBC_SLV_BASE + 64'h20, 1'b1, 64'hc3);
        check("mem wdata", mem_wd, 64'hc3);
        check("mem write", 64'(mem_wr), 64'h1);
        check("mem addr", mem_addr, `VBC_SLV_BASE + 64'h20);
        mem_rdata = 64'h3c;
        slv_rdata = 64'h66;
        // both masters at once must take turns
        fork
            host_run(VBC_OP_RD, VBC_SP_A32, VBC_SZ_D32, 1'b0, 64'h8000_4000, 0, 0);
            brd_run(`VBC_AM_A32_UD, `VBC_SLV_BASE + 64'h10, 1'b0, 0);
        join
        check("host rd shared", host_rdata, 64'h66);
        check("board rd", mst_rdata, 64'h3c);
        for (int l = 1; l <= 7; l++)
        begin
            @(negedge clk);
            irq_enable = 7'h01 << (l - 1);
            irq_lvl = 3'(l);
            brd_vec = 8'h10 + 8'(l);
            irq_req = 1'b1;
            // one-cycle request: a held one pends again after its acknowledge
            @(negedge clk);
            irq_req = 1'b0;
            wait_hi(cpu_irq);
            check("irq level", irq_level, 64'(l));
            check("irq vector", irq_vector, 64'h10 + l);
            cpu_irq_clr = 1'b1;
            @(negedge clk);
            cpu_irq_clr = 1'b0;
            @(negedge clk);
            check("irq cleared", cpu_irq, 64'h0);
        end
        check("irq acks", 64'(n_ack), 64'h7);
        irq_enable = 7'h1f;
        irq_lvl = 3'h6;
        irq_req = 1'b1;
        iack_seen = 1'b0;
        repeat (40) @(negedge clk);
        check("quiet cpu irq", cpu_irq, 64'h0);
        check("quiet iack", iack_seen, 64'h0);
        // a24 code at the a32 window: must not reach host memory
        mreq_seen = 1'b0;
        mst_am = `VBC_AM_A24_UD;
        mst_req = 1'b1;
        repeat (40) @(negedge clk);
        check("space miss", mreq_seen, 64'h0);
        mst_req = 1'b0;
        irq_req = 1'b0;
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        check("rst cpu irq", cpu_irq, 64'h0);
        check("rst mem req", mem_req, 64'h0);
        check("rst rdata", host_rdata, 64'h0);
        host_run(VBC_OP_RD, VBC_SP_A32, VBC_SZ_D32, 1'b0, 64'h8000_5000, 0, 0);
        check("after rst rd", host_rdata, 64'h66);
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule
